// file: hdl/cmfp_map.svh
// Register offsets, field positions and reset values of the CAN mode and filter pointer block
// Assumes an APB slave with 32-bit data, one register per aligned word
`ifndef CMFP_MAP_SVH
`define CMFP_MAP_SVH

`define CMFP_OFF_MODE_CTRL   12'h000
`define CMFP_OFF_PTR_4_7     12'h004
`define CMFP_OFF_PTR_8_11    12'h008
`define CMFP_OFF_MODE_STAT   12'h00c

`define CMFP_BIT_CSIDL       13
`define CMFP_BIT_ABORT       12
`define CMFP_BIT_CLKSEL      11
`define CMFP_REQ_MSB         10
`define CMFP_REQ_LSB         8
`define CMFP_CUR_MSB         7
`define CMFP_CUR_LSB         5
`define CMFP_BIT_CAPEN       3
`define CMFP_BIT_WIN         0
`define CMFP_STAT_BIT_BUSY   0

`define CMFP_MODE_RESET      3'h4
`define CMFP_PTR_RESET       16'h0000
`define CMFP_DEST_FIFO       4'hf
`define CMFP_FIELD_W         4
`define CMFP_NUM_FILT        8
`define CMFP_FIRST_FILT      4
`define CMFP_FILT_SEL_W      4

`endif

// file: hdl/cmfp_pkg.sv
// Types shared by the CAN mode and filter pointer block
// Assumes the map header for numeric constants
package cmfp_pkg;

  typedef enum logic [2:0] {
    CMFP_MODE_NORMAL   = 3'h0,
    CMFP_MODE_DISABLE  = 3'h1,
    CMFP_MODE_LOOPBACK = 3'h2,
    CMFP_MODE_LISTEN   = 3'h3,
    CMFP_MODE_CONFIG   = 3'h4,
    CMFP_MODE_RSVD5    = 3'h5,
    CMFP_MODE_RSVD6    = 3'h6,
    CMFP_MODE_LISTALL  = 3'h7
  } cmfp_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cmfp_apb_req_t;

  typedef struct packed {
    logic       hit;
    logic [3:0] filter;
  } cmfp_hit_t;

  typedef struct packed {
    logic       valid;
    logic       to_fifo;
    logic [3:0] buffer;
  } cmfp_route_t;

endpackage : cmfp_pkg

// file: hdl/cmfp_ctrl.sv
// CAN mode request/report, abort-all, capture-on-receive and filter destination pointers
// Assumes an APB master on i_core_clk and a protocol engine that acknowledges mode
// changes and the completion of a transmit abort with one-cycle pulses
//
// Operation
// R1: Writing one to abort-all signals every tx buffer; self-clears when all aborted.
// R2: Requested mode field takes 111,100,011,010,001; 110/101 reserved; resets to 100.
// R3: Current mode field is read-only, reports active mode, reads 100 after reset.
// R4: Capture enable set gives a capture event per received message, else none.
// R5: Four-bit destination: 0000-1110 pick rx buffer 0-14, 1111 picks rx FIFO.
// R6: Pointer regs hold filters 4-7 and 8-11, four bits each, reset to zero.
// R7: Current mode keeps old value until the engine finishes the transition.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "cmfp_map.svh"

module cmfp_ctrl
  import cmfp_pkg::*;
(
  input  wire logic        i_core_clk,      // Module clock, 250 MHz
  input  wire logic        i_reset_n,       // Asynchronous reset, active low
  input  wire logic        i_psel,          // APB select
  input  wire logic        i_penable,       // APB enable
  input  wire logic        i_pwrite,        // APB direction, high for write
  input  wire logic [11:0] i_paddr,         // APB byte address
  input  wire logic [31:0] i_pwdata,        // APB write data
  input  wire logic [3:0]  i_pstrb,         // APB byte strobes
  output logic      [31:0] o_prdata,        // APB read data
  output logic             o_pready,        // APB ready
  output logic             o_pslverr,       // APB error, unmapped address
  output logic      [2:0]  o_req_mode,      // Requested mode to engine
  input  wire logic        i_mode_done,     // Engine finished a mode change
  input  wire logic [2:0]  i_mode_active,   // Mode engine entered on done
  output logic             o_abort_all_tx,  // Abort request level to tx buffers
  input  wire logic        i_abort_done,    // All pending transmissions aborted
  input  wire logic        i_rx_done,       // Message received, one cycle
  output logic             o_capture_evt,   // Capture trigger, one cycle
  output logic             o_stop_in_idle,  // Stop in idle control
  output logic             o_clk_sel,       // Module clock source select
  output logic             o_win_sel,       // Register window select
  input  wire logic        i_filt_hit,      // Acceptance filter hit
  input  wire logic [3:0]  i_filt_num,      // Index of the hitting filter
  output logic             o_route_valid,   // Routing result valid
  output logic             o_route_fifo,    // Message goes to rx FIFO
  output logic      [3:0]  o_route_buf      // Rx buffer number
);

  cmfp_apb_req_t req;
  logic          wr_en;
  logic          rd_en;
  logic          addr_ok;
  logic [15:0]   ptr_4_7_reg;
  logic [15:0]   ptr_8_11_reg;
  logic [2:0]    req_mode_reg;
  cmfp_mode_t    cur_mode_reg;
  logic          abort_reg;
  logic          capen_reg;
  logic          csidl_reg;
  logic          clksel_reg;
  logic          win_reg;
  logic          capture_reg;
  cmfp_route_t   route_reg;
  cmfp_route_t   route_next;
  logic [15:0]   ctrl_rd;
  logic [3:0]    dest_sel [`CMFP_NUM_FILT];
  logic [`CMFP_NUM_FILT-1:0] filt_match;
  logic [3:0]    route_sel;
  logic [31:0]   rd_mux;
  logic [31:0]   prdata_reg;
  logic          sel_ctrl;
  logic          sel_ptr_4_7;
  logic          sel_ptr_8_11;
  logic          sel_stat;
  logic          req_code_ok;

  assign req     = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                     paddr: i_paddr, pwdata: i_pwdata};
  // Address decode, one line per register
  assign sel_ctrl     = (req.paddr == `CMFP_OFF_MODE_CTRL);
  assign sel_ptr_4_7  = (req.paddr == `CMFP_OFF_PTR_4_7);
  assign sel_ptr_8_11 = (req.paddr == `CMFP_OFF_PTR_8_11);
  assign sel_stat     = (req.paddr == `CMFP_OFF_MODE_STAT);
  assign addr_ok = sel_ctrl || sel_ptr_4_7 || sel_ptr_8_11 || sel_stat;
  assign wr_en   = req.psel && req.penable && req.pwrite && addr_ok;
  // Read data is decoded in the setup cycle and held in a flop for the access phase
  assign rd_en   = req.psel && !req.penable && !req.pwrite;

  // Reserved codes and the normal code are refused; the previous request stays
  assign req_code_ok = (req.pwdata[`CMFP_REQ_MSB:`CMFP_REQ_LSB] != CMFP_MODE_RSVD5) &&
                       (req.pwdata[`CMFP_REQ_MSB:`CMFP_REQ_LSB] != CMFP_MODE_RSVD6) &&
                       (req.pwdata[`CMFP_REQ_MSB:`CMFP_REQ_LSB] != CMFP_MODE_NORMAL);
  assign o_pready  = 1'b1;
  assign o_pslverr = req.psel && req.penable && !addr_ok;

  // Control bits, lower byte strobe carries none that are writable except capture and window
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      req_mode_reg <= `CMFP_MODE_RESET;                                     // [R2]
      capen_reg    <= 1'b0;
      csidl_reg    <= 1'b0;
      clksel_reg   <= 1'b0;
      win_reg      <= 1'b0;
    end
    else if (wr_en && req.paddr == `CMFP_OFF_MODE_CTRL)
    begin
      if (i_pstrb[1])
      begin
        if (req_code_ok)
          req_mode_reg <= req.pwdata[`CMFP_REQ_MSB:`CMFP_REQ_LSB];         // [R2]
        csidl_reg  <= req.pwdata[`CMFP_BIT_CSIDL];
        clksel_reg <= req.pwdata[`CMFP_BIT_CLKSEL];
      end
      if (i_pstrb[0])
      begin
        capen_reg <= req.pwdata[`CMFP_BIT_CAPEN];
        win_reg   <= req.pwdata[`CMFP_BIT_WIN];
      end
    end
  end

  // Abort-all: set by software, cleared by the engine; a new set wins over the clear
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      abort_reg <= 1'b0;                                                   // [R1]
    else if (wr_en && req.paddr == `CMFP_OFF_MODE_CTRL && i_pstrb[1] &&
             req.pwdata[`CMFP_BIT_ABORT])
      abort_reg <= 1'b1;                                                   // [R1]
    else if (i_abort_done)
      abort_reg <= 1'b0;                                                   // [R1]
  end

  // Current mode follows only on the engine's completion
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cur_mode_reg <= CMFP_MODE_CONFIG;                                    // [R3]
    else if (i_mode_done)
      cur_mode_reg <= cmfp_mode_t'(i_mode_active);                         // [R7]
  end

  // Filter destination pointers with byte strobes
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ptr_4_7_reg  <= `CMFP_PTR_RESET;                                      // [R6]
      ptr_8_11_reg <= `CMFP_PTR_RESET;                                      // [R6]
    end
    else if (wr_en)
    begin
      if (req.paddr == `CMFP_OFF_PTR_4_7)
      begin
        if (i_pstrb[0])
          ptr_4_7_reg[7:0] <= req.pwdata[7:0];                             // [R6]
        if (i_pstrb[1])
          ptr_4_7_reg[15:8] <= req.pwdata[15:8];                           // [R6]
      end
      if (req.paddr == `CMFP_OFF_PTR_8_11)
      begin
        if (i_pstrb[0])
          ptr_8_11_reg[7:0] <= req.pwdata[7:0];                            // [R6]
        if (i_pstrb[1])
          ptr_8_11_reg[15:8] <= req.pwdata[15:8];                          // [R6]
      end
    end
  end

  // Capture event per received message while enabled
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      capture_reg <= 1'b0;
    else
      capture_reg <= capen_reg && i_rx_done;                               // [R4]
  end

  // Split pointer registers into per-filter fields, filter 4 in the low nibble
  genvar gi;
  generate
    for (gi = 0; gi < `CMFP_NUM_FILT; gi++)
    begin : g_dest
      if (gi < `CMFP_FILT_SEL_W)
      begin : g_lo
        assign dest_sel[gi] = ptr_4_7_reg[gi*`CMFP_FIELD_W +: `CMFP_FIELD_W];   // [R6]
      end
      else
      begin : g_hi
        assign dest_sel[gi] =
          ptr_8_11_reg[(gi-`CMFP_FILT_SEL_W)*`CMFP_FIELD_W +: `CMFP_FIELD_W];   // [R6]
      end
    end
  endgenerate

  // One match line per steered filter; filters outside the range match none
  generate
    for (gi = 0; gi < `CMFP_NUM_FILT; gi++)
    begin : g_match
      assign filt_match[gi] = i_filt_hit &&
                              (i_filt_num == 4'(`CMFP_FIRST_FILT + gi));
    end
  endgenerate

  // Route a filter hit; filters outside 4-11 are not steered here
  always_comb
  begin
    route_next = '0;
    route_sel  = '0;
    for (int fi = 0; fi < `CMFP_NUM_FILT; fi++)
    begin
      if (filt_match[fi])
        route_sel = dest_sel[fi];                                          // [R6]
    end
    if (|filt_match)
    begin
      route_next.valid = 1'b1;
      if (route_sel == `CMFP_DEST_FIFO)
        route_next.to_fifo = 1'b1;                                         // [R5]
      else
        route_next.buffer = route_sel;                                     // [R5]
    end
  end

  // Route result is registered so that it stands one full cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      route_reg <= '0;
    else
      route_reg <= route_next;
  end

  // Control word layout, upper half of the bus reads zero:
  //   13     stop in idle
  //   12     abort all transmissions, cleared by the engine
  //   11     module clock source select
  //   10:8   requested mode
  //   7:5    current mode, read only
  //   3      capture on receive enable
  //   0      register window select
  // Status word bit 0 is high while a mode change is pending
  // Pointer words hold four destination nibbles, lowest filter in bits 3:0
  always_comb
  begin
    ctrl_rd = '0;
    ctrl_rd[`CMFP_BIT_CSIDL]                  = csidl_reg;
    ctrl_rd[`CMFP_BIT_ABORT]                  = abort_reg;
    ctrl_rd[`CMFP_BIT_CLKSEL]                 = clksel_reg;
    ctrl_rd[`CMFP_REQ_MSB:`CMFP_REQ_LSB]      = req_mode_reg;
    ctrl_rd[`CMFP_CUR_MSB:`CMFP_CUR_LSB]      = cur_mode_reg;              // [R3]
    ctrl_rd[`CMFP_BIT_CAPEN]                  = capen_reg;
    ctrl_rd[`CMFP_BIT_WIN]                    = win_reg;
  end

  always_comb
  begin
    rd_mux = '0;
    if (rd_en)
    begin
      unique case (req.paddr)
        `CMFP_OFF_MODE_CTRL: rd_mux = {16'h0000, ctrl_rd};
        `CMFP_OFF_PTR_4_7:   rd_mux = {16'h0000, ptr_4_7_reg};
        `CMFP_OFF_PTR_8_11:  rd_mux = {16'h0000, ptr_8_11_reg};
        `CMFP_OFF_MODE_STAT: rd_mux = {31'h00000000,
                                       cur_mode_reg != cmfp_mode_t'(req_mode_reg)};
        default:             rd_mux = '0;
      endcase
    end
  end

  // Read data flop: loaded at the end of the setup cycle, stands through the access
  // phase and clears afterwards, so the bus shows zero outside a read
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prdata_reg <= '0;
    else if (rd_en)
      prdata_reg <= rd_mux;
    else
      prdata_reg <= '0;
  end

  assign o_prdata       = prdata_reg;
  assign o_req_mode     = req_mode_reg;
  assign o_abort_all_tx = abort_reg;                                       // [R1]
  assign o_capture_evt  = capture_reg;
  assign o_stop_in_idle = csidl_reg;
  assign o_clk_sel      = clksel_reg;
  assign o_win_sel      = win_reg;
  assign o_route_valid  = route_reg.valid;
  assign o_route_fifo   = route_reg.to_fifo;
  assign o_route_buf    = route_reg.buffer;

endmodule : cmfp_ctrl

// file: sim/cmfp_ctrl_monitor.sv
// Assertion checker on the ports of the CAN mode and filter pointer block
// Assumes a bind onto cmfp_ctrl with zero-wait APB transfers
`timescale 1ns/100ps
module cmfp_ctrl_monitor (
  input wire logic        i_core_clk,     // Clock
  input wire logic        i_reset_n,      // Reset
  input wire logic        i_psel,         // APB select
  input wire logic        i_penable,      // APB enable
  input wire logic        i_pwrite,       // APB write
  input wire logic [11:0] i_paddr,        // APB address
  input wire logic [31:0] o_prdata,       // APB read data
  input wire logic [2:0]  o_req_mode,     // Requested mode
  input wire logic        i_mode_done,    // Mode done
  input wire logic [2:0]  i_mode_active,  // Mode entered
  input wire logic        o_abort_all_tx, // Abort level
  input wire logic        i_abort_done,   // Abort done
  input wire logic        i_rx_done,      // Receive pulse
  input wire logic        o_capture_evt,  // Capture pulse
  input wire logic        i_filt_hit,     // Filter hit
  input wire logic [3:0]  i_filt_num,     // Filter index
  input wire logic        o_route_valid,  // Route valid
  input wire logic        o_route_fifo,   // Route to FIFO
  input wire logic [3:0]  o_route_buf     // Route buffer
);
  logic       wr_ctl;
  logic       in_rng;
  logic [2:0] cur_reg;
  assign wr_ctl = i_psel && i_penable && i_pwrite && (i_paddr == 12'h000);
  assign in_rng = i_filt_hit && (i_filt_num >= 4'h4) && (i_filt_num <= 4'hb);
  // Mode last reported by the engine
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n) cur_reg <= 3'h4;
    else if (i_mode_done) cur_reg <= i_mode_active;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  AST_ABORT_HOLD: assert property (o_abort_all_tx && !i_abort_done |=> o_abort_all_tx)
    else $error("abort request dropped early");
  AST_REQ_LEGAL: assert property (o_req_mode inside {3'h7, 3'h4, 3'h3, 3'h2, 3'h1})
    else $error("requested mode holds a refused code");
  AST_REQ_HOLD: assert property (!wr_ctl |=> $stable(o_req_mode))
    else $error("requested mode changed without a write");
  AST_CUR_READ: assert property (i_psel && i_penable && !i_pwrite && i_paddr == 12'h000
    |-> o_prdata[7:5] == $past(cur_reg)) else $error("current mode readback wrong");
  AST_CAP_CAUSE: assert property (o_capture_evt |-> $past(i_rx_done))
    else $error("capture event without a received message");
  AST_ROUTE_FIFO: assert property (o_route_valid && o_route_fifo |-> o_route_buf == 4'h0)
    else $error("fifo route carries a buffer number");
  AST_ROUTE_MAP: assert property (1'b1 |=> o_route_valid == $past(in_rng))
    else $error("route valid does not follow an in-range hit");
endmodule : cmfp_ctrl_monitor
bind cmfp_ctrl cmfp_ctrl_monitor i_cmfp_ctrl_monitor (.i_core_clk, .i_reset_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_req_mode, .i_mode_done, .i_mode_active,
  .o_abort_all_tx, .i_abort_done, .i_rx_done, .o_capture_evt, .i_filt_hit, .i_filt_num,
  .o_route_valid, .o_route_fifo, .o_route_buf);

// file: sim/cmfp_engine_model.sv
// Protocol engine stand-in: acknowledges mode requests and transmit aborts
// Assumes levels from the block on i_core_clk; the bench sets the answer delay
`timescale 1ns/100ps
module cmfp_engine_model (
  input  wire logic       i_core_clk,    // Clock
  input  wire logic       i_reset_n,     // Reset
  input  wire logic [3:0] i_delay,       // Answer delay
  input  wire logic [2:0] i_req_mode,    // Requested mode
  input  wire logic       i_abort,       // Abort level
  output logic            o_mode_done,   // Mode done pulse
  output logic      [2:0] o_mode_active, // Mode entered
  output logic            o_abort_done   // Abort done pulse
);
  logic [2:0] cur_reg;
  logic [3:0] mcnt_reg;
  logic [3:0] acnt_reg;
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      cur_reg <= 3'h4;
      mcnt_reg <= 4'h0;
      acnt_reg <= 4'h0;
      o_mode_done <= 1'b0;
      o_mode_active <= 3'h3;
      o_abort_done <= 1'b0;
    end
    else
    begin
      // Mode bus toggles outside the done cycle
      o_mode_done <= 1'b0;
      o_mode_active <= ~o_mode_active;
      mcnt_reg <= (i_req_mode == cur_reg) ? 4'h0 : mcnt_reg + 4'h1;
      if (i_req_mode != cur_reg && mcnt_reg == i_delay)
      begin
        o_mode_done <= 1'b1;
        o_mode_active <= i_req_mode;
        cur_reg <= i_req_mode;
      end
      o_abort_done <= i_abort && !o_abort_done && acnt_reg == i_delay;
      acnt_reg <= (i_abort && !o_abort_done) ? acnt_reg + 4'h1 : 4'h0;
    end
endmodule : cmfp_engine_model

// file: sim/cmfp_ctrl_tb_top.sv
// Self-checking bench for the CAN mode and filter pointer block
// Assumes the engine model and the checker bind are compiled alongside
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module cmfp_ctrl_tb_top
  import cmfp_pkg::*;
;
  logic          clk, rst_n, rx, hit, se, pready, pslverr, abort, mdone, adone, cap, rv, rf;
  cmfp_apb_req_t req;
  logic [3:0]    strb, num, dly, rb;
  logic [2:0]    req_mode, act;
  logic [31:0]   prdata;
  int            err_total, total_checks;
  cmfp_ctrl i_cmfp_ctrl (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(req.psel),
    .i_penable(req.penable), .i_pwrite(req.pwrite), .i_paddr(req.paddr),
    .i_pwdata(req.pwdata), .i_pstrb(strb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_req_mode(req_mode), .i_mode_done(mdone), .i_mode_active(act),
    .o_abort_all_tx(abort), .i_abort_done(adone), .i_rx_done(rx), .o_capture_evt(cap),
    .o_stop_in_idle(), .o_clk_sel(), .o_win_sel(), .i_filt_hit(hit), .i_filt_num(num),
    .o_route_valid(rv), .o_route_fifo(rf), .o_route_buf(rb));
  cmfp_engine_model i_cmfp_engine_model (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_delay(dly), .i_req_mode(req_mode), .i_abort(abort), .o_mode_done(mdone),
    .o_mode_active(act), .o_abort_done(adone));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    r = prdata;
    se = pslverr;
    req <= '0;
  endtask : apb
  task automatic t_reset();
    logic [31:0] r;
    apb(1'b0, 12'h000, 32'h0, r);
    `CHK(r, 32'h0000_0480)
    apb(1'b1, 12'h010, 32'hffff, r);
    `CHK(se, 1'b1)
    for (int i = 4; i < 9; i += 4)
    begin
      apb(1'b0, i[11:0], 32'h0, r);
      `CHK(r, 32'h0)
    end
  endtask : t_reset
  task automatic t_modes();
    logic [2:0]  codes [8];
    logic [2:0]  exp, old;
    logic [31:0] r;
    int          k;
    codes = '{3'h7, 3'h4, 3'h3, 3'h2, 3'h1, 3'h5, 3'h6, 3'h0};
    exp = 3'h4;
    for (int i = 0; i < 8; i++)
    begin
      old = exp;
      if (i < 5) exp = codes[i];
      dly <= i[0] ? 4'h0 : 4'h9;
      apb(1'b1, 12'h000, {21'h0, codes[i], 8'h00}, r);
      @(negedge clk);
      `CHK(req_mode, exp)
      apb(1'b0, 12'h000, 32'h0, r);
      if (!i[0]) `CHK(r[7:5], old)
      for (k = 0; k < 30 && mdone !== 1'b1; k++) @(posedge clk);
      apb(1'b0, 12'h000, 32'h0, r);
      `CHK(r[7:5], exp)
    end
  endtask : t_modes
  task automatic t_abort();
    logic [31:0] r;
    dly <= 4'hf;
    apb(1'b1, 12'h000, 32'h0000_1100, r);
    @(negedge clk);
    `CHK(abort, 1'b1)
    apb(1'b1, 12'h000, 32'h0000_0100, r);
    apb(1'b0, 12'h000, 32'h0, r);
    `CHK(r[12], 1'b1)
    for (int k = 0; k < 30 && abort === 1'b1; k++) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0, r);
    `CHK(r[12], 1'b0)
  endtask : t_abort
  task automatic t_capture();
    logic [31:0] r;
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, 12'h000, i ? 32'h0000_0100 : 32'h0000_0108, r);
      @(posedge clk);
      rx <= 1'b1;
      @(posedge clk);
      rx <= 1'b0;
      @(negedge clk);
      `CHK(cap, (i == 0))
      @(negedge clk);
      `CHK(cap, 1'b0)
    end
  endtask : t_capture
  task automatic t_route();
    logic [31:0] pt, r;
    logic [3:0]  f;
    pt = 32'h1f3a_f7e0;
    apb(1'b1, 12'h004, {16'h0, pt[15:0]}, r);
    apb(1'b1, 12'h008, {16'h0, pt[31:16]}, r);
    apb(1'b0, 12'h008, 32'h0, r);
    `CHK(r, {16'h0, pt[31:16]})
    for (int i = 0; i < 16; i++)
    begin
      f = pt[4 * ((i - 4) & 7) +: 4];
      @(posedge clk);
      hit <= 1'b1;
      num <= i[3:0];
      @(posedge clk);
      hit <= 1'b0;
      @(negedge clk);
      `CHK(rv, (i > 3 && i < 12))
      if (i > 3 && i < 12) `CHK({rf, rb}, (f == 4'hf) ? 5'h10 : {1'b0, f})
    end
  endtask : t_route
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {rst_n, rx, hit, num, dly, err_total, total_checks} = '0;
    req = '0;
    strb = 4'h3;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_abort();
    t_capture();
    t_route();
    finish_test();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : cmfp_ctrl_tb_top
